// File: hw/hmme_exec.v
// Execution datapath: halfword multiplies, register copy, control-file transfer, constant loads.
// Assumes the issue stage supplies operands, a resolved condition and the issuing unit each cycle.
`timescale 1ns/1ps
`include "hmme_defs.vh"

module hmme_exec (
	input  wire                     ref_clk_in,
	input  wire                     nrst_in,
	input  wire                     issue_in,
	input  wire [`HMME_OP_W-1:0]    op_in,
	input  wire [`HMME_UNIT_W-1:0]  unit_in,
	input  wire                     cond_in,
	input  wire [31:0]              src1_in,
	input  wire                     src1_is_cst5_in,
	input  wire [4:0]               cst5_in,
	input  wire [31:0]              src2_in,
	input  wire [15:0]              cst16_in,
	input  wire [31:0]              dst_old_in,
	input  wire [4:0]               dst_addr_in,
	input  wire [4:0]               ctl_addr_in,
	input  wire [31:0]              pc_e1_in,
	input  wire [31:0]              ctl_csr_in,
	output reg                      wr_en_out,
	output reg  [4:0]               wr_addr_out,
	output reg  [31:0]              wr_data_out,
	output reg                      illegal_unit_out,
	output wire [31:0]              amr_out,
	output wire [31:0]              csr_out,
	output wire [31:0]              iflag_out,
	output wire [31:0]              ien_out,
	output wire [31:0]              vtp_out,
	output wire [31:0]              irp_out,
	output wire [31:0]              nrp_out
);

////////////////////////////////////////////////////////////////////////////////
// Issue decode
wire        go     = issue_in & cond_in;
wire        is_mul = (op_in == `HMME_OP_MUL_ULSH) | (op_in == `HMME_OP_MUL_SLUL) |
                     (op_in == `HMME_OP_MUL_ULUL) | (op_in == `HMME_OP_MUL_ULSL);
wire        is_ctl = (op_in == `HMME_OP_CTL_RD) | (op_in == `HMME_OP_CTL_WR);
wire        on_s   = (unit_in == `HMME_UNIT_S1) | (unit_in == `HMME_UNIT_S2);
reg         unit_ok;

always @* begin
	unit_ok = 1'b0;
	if (is_mul)
		unit_ok = (unit_in == `HMME_UNIT_M);
	else if (is_ctl)
		unit_ok = (unit_in == `HMME_UNIT_S2);
	else if (op_in == `HMME_OP_COPY)
		unit_ok = on_s | (unit_in == `HMME_UNIT_L) | (unit_in == `HMME_UNIT_D);
	else if (op_in == `HMME_OP_CONST || op_in == `HMME_OP_UPPER)
		unit_ok = on_s;
end

wire        act    = go & unit_ok;

////////////////////////////////////////////////////////////////////////////////
// Multiplier operands, sign chosen per variant
reg  signed [16:0] ma;
reg  signed [16:0] mb;
wire signed [33:0] prod = ma * mb;

always @* begin
	ma = {1'b0, src1_in[15:0]};
	mb = {1'b0, src2_in[15:0]};
	case (op_in)
	`HMME_OP_MUL_ULSH: begin
		mb = {src2_in[31], src2_in[31:16]};
	end
	`HMME_OP_MUL_SLUL: begin
		if (src1_is_cst5_in)
			ma = {{12{cst5_in[4]}}, cst5_in};
		else
			ma = {src1_in[15], src1_in[15:0]};
	end
	`HMME_OP_MUL_ULSL: begin
		mb = {src2_in[15], src2_in[15:0]};
	end
	default: begin
		ma = {1'b0, src1_in[15:0]};
	end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Control register file
reg  [31:0] amr_q;
reg  [31:0] csr_q;
reg  [31:0] iflag_q;
reg  [31:0] ien_q;
reg  [31:0] vtp_q;
reg  [31:0] irp_q;
reg  [31:0] nrp_q;
reg  [31:0] iset_q;
reg  [31:0] iclr_q;
reg         ipend_q;

wire        ctl_wr = act & (op_in == `HMME_OP_CTL_WR);
// Set and clear are staged one cycle so the flag view lags by two cycles
wire        iset_w = ctl_wr & (ctl_addr_in == `HMME_CA_IFLAG_ISET);
wire        iclr_w = ctl_wr & (ctl_addr_in == `HMME_CA_ICLR);

always @(posedge ref_clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		amr_q   <= `HMME_REG_RST;
		csr_q   <= `HMME_REG_RST;
		iflag_q <= `HMME_REG_RST;
		ien_q   <= `HMME_REG_RST;
		vtp_q   <= `HMME_REG_RST;
		irp_q   <= `HMME_REG_RST;
		nrp_q   <= `HMME_REG_RST;
		iset_q  <= `HMME_REG_RST;
		iclr_q  <= `HMME_REG_RST;
		ipend_q <= 1'b0;
	end else begin
		ipend_q <= iset_w | iclr_w;
		iset_q  <= iset_w ? src2_in : 32'h0000_0000;
		iclr_q  <= iclr_w ? src2_in : 32'h0000_0000;
		if (ipend_q)
			iflag_q <= (iflag_q & ~iclr_q) | iset_q;
		if (ctl_wr) begin
			case (ctl_addr_in)
			`HMME_CA_AMR: amr_q <= (amr_q & ~`HMME_AMR_WMASK) | (src2_in & `HMME_AMR_WMASK);
			`HMME_CA_CSR: csr_q <= src2_in;
			`HMME_CA_IEN: ien_q <= src2_in;
			`HMME_CA_VTP: vtp_q <= src2_in;
			`HMME_CA_IRP: irp_q <= src2_in;
			`HMME_CA_NRP: nrp_q <= src2_in;
			default: ;
			endcase
		end
	end
end

reg  [31:0] ctl_rd;
always @* begin
	case (ctl_addr_in)
	`HMME_CA_AMR:        ctl_rd = amr_q;
	`HMME_CA_CSR:        ctl_rd = csr_q | ctl_csr_in;
	`HMME_CA_IFLAG_ISET: ctl_rd = iflag_q;
	`HMME_CA_IEN:        ctl_rd = ien_q;
	`HMME_CA_VTP:        ctl_rd = vtp_q;
	`HMME_CA_IRP:        ctl_rd = irp_q;
	`HMME_CA_NRP:        ctl_rd = nrp_q;
	`HMME_CA_FIRST_PHASE_PROGRAM_COUNTER:       ctl_rd = pc_e1_in;
	default:             ctl_rd = 32'h0000_0000;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Single-cycle results, written at the end of the issue cycle
reg         one_we;
reg  [31:0] one_data;
always @* begin
	one_we   = act;
	one_data = 32'h0000_0000;
	case (op_in)
	`HMME_OP_COPY:   one_data = src2_in + 32'h0000_0000;
	`HMME_OP_CTL_RD: one_data = ctl_rd;
	`HMME_OP_CONST:  one_data = {{16{cst16_in[15]}}, cst16_in};
	`HMME_OP_UPPER:  one_data = {cst16_in, dst_old_in[15:0]};
	default:         one_we   = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Multiply pipeline: E1 captures product, E2 writes back
reg         m1_v_q;
reg  [4:0]  m1_a_q;
reg  [31:0] m1_p_q;

always @(posedge ref_clk_in or negedge nrst_in) begin
	if (!nrst_in) begin
		m1_v_q           <= 1'b0;
		m1_a_q           <= 5'h00;
		m1_p_q           <= 32'h0000_0000;
		wr_en_out        <= 1'b0;
		wr_addr_out      <= 5'h00;
		wr_data_out      <= 32'h0000_0000;
		illegal_unit_out <= 1'b0;
	end else begin
		m1_v_q           <= act & is_mul;
		m1_a_q           <= dst_addr_in;
		m1_p_q           <= prod[31:0];
		illegal_unit_out <= go & ~unit_ok & (op_in != `HMME_OP_NOP);
		// Multiply write-back takes the port; issue must avoid a same-cycle single-cycle write
		if (m1_v_q) begin
			wr_en_out   <= 1'b1;
			wr_addr_out <= m1_a_q;
			wr_data_out <= m1_p_q;
		end else begin
			wr_en_out   <= one_we;
			wr_addr_out <= dst_addr_in;
			wr_data_out <= one_data;
		end
	end
end

assign amr_out   = amr_q;
assign csr_out   = csr_q;
assign iflag_out = iflag_q;
assign ien_out   = ien_q;
assign vtp_out   = vtp_q;
assign irp_out   = irp_q;
assign nrp_out   = nrp_q;

endmodule

// File: hw/hmme_defs.vh
// Constants for the halfword multiply and move execution datapath.
// Assumes a core clock of 20 MHz and an issue stage driving one slot per cycle.
// Notes on behaviour
// - Unsigned low of src1 times signed high of src2 gives signed 32-bit product.
// - Signed low src1 (or sign-extended 5-bit constant) times unsigned low src2.
// - Unsigned low times unsigned low gives unsigned 32-bit product.
// - Unsigned low src1 times signed low src2 gives signed 32-bit product.
// - Multiplies run on the multiply unit; result visible two cycles after issue.
// - Register copy adds zero to source; single cycle on logic, shift, address units.
// - Control-file transfer accepted only on the second-side shift unit.
// - Control-file transfer moves 32 bits either way in one cycle.
// - Flag register shows set/clear writes only two cycles after the write.
// - Six top bits of addressing mode register are reserved, never written.
// - Decode 5-bit control address; 00010 reads flags, writes set; 00011 write-only.
// - Signed constant load sign-extends 16-bit immediate to 32 bits.
// - Constant loads run on shift units; result visible one cycle after issue.
// - Upper-half load writes immediate to top half, keeps low 16 bits.
`ifndef HMME_DEFS_VH
`define HMME_DEFS_VH

// Operation codes
`define HMME_OP_W           4
`define HMME_OP_NOP         4'h0
`define HMME_OP_MUL_ULSH    4'h1
`define HMME_OP_MUL_SLUL    4'h2
`define HMME_OP_MUL_ULUL    4'h3
`define HMME_OP_MUL_ULSL    4'h4
`define HMME_OP_COPY        4'h5
`define HMME_OP_CTL_RD      4'h6
`define HMME_OP_CTL_WR      4'h7
`define HMME_OP_CONST       4'h8
`define HMME_OP_UPPER       4'h9

// Unit codes
`define HMME_UNIT_W         3
`define HMME_UNIT_L         3'h0
`define HMME_UNIT_S1        3'h1
`define HMME_UNIT_S2        3'h2
`define HMME_UNIT_M         3'h3
`define HMME_UNIT_D         3'h4

// Control register addresses
`define HMME_CA_AMR         5'h00
`define HMME_CA_CSR         5'h01
`define HMME_CA_IFLAG_ISET  5'h02
`define HMME_CA_ICLR        5'h03
`define HMME_CA_IEN         5'h04
`define HMME_CA_VTP         5'h05
`define HMME_CA_IRP         5'h06
`define HMME_CA_NRP         5'h07
`define HMME_CA_FIRST_PHASE_PROGRAM_COUNTER        5'h10

// Field layout and reset values
`define HMME_AMR_WMASK      32'h03ff_ffff
`define HMME_REG_RST        32'h0000_0000

`endif

// File: dv/hmme_exec_props.sv
// Port-level timing and result checks for hmme_exec.
// Bound to every hmme_exec instance; sees its ports only.
`timescale 1ns/1ps
`include "hmme_defs.vh"
module hmme_exec_props (
	input wire        ref_clk_in,
	input wire        nrst_in,
	input wire        issue_in,
	input wire        cond_in,
	input wire [3:0]  op_in,
	input wire [2:0]  unit_in,
	input wire [4:0]  ctl_addr_in,
	input wire [15:0] cst16_in,
	input wire [31:0] src1_in,
	input wire [31:0] src2_in,
	input wire [31:0] dst_old_in,
	input wire        wr_en_out,
	input wire        illegal_unit_out,
	input wire [31:0] wr_data_out,
	input wire [31:0] amr_out,
	input wire [31:0] iflag_out
);
	wire               go = issue_in && cond_in;
	wire               on_s = unit_in == `HMME_UNIT_S1 || unit_in == `HMME_UNIT_S2;
	wire               cw2 = go && op_in == `HMME_OP_CTL_WR && unit_in == `HMME_UNIT_S2;
	// Signed products sized here so the compare cannot zero-extend them
	wire signed [31:0] p_uh = $signed({1'b0, src1_in[15:0]}) * $signed(src2_in[31:16]);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	mul_uu_a: assert property (go && op_in == `HMME_OP_MUL_ULUL && unit_in == `HMME_UNIT_M |=> !wr_en_out ##1
		wr_en_out && wr_data_out == $past(src1_in[15:0], 2) * $past(src2_in[15:0], 2)) else $error("mul uu");
	mul_uh_a: assert property (go && op_in == `HMME_OP_MUL_ULSH && unit_in == `HMME_UNIT_M |-> ##2
		wr_data_out == $past(p_uh, 2)) else $error("mul uh");
	copy_res_a: assert property (go && op_in == `HMME_OP_COPY && unit_in != `HMME_UNIT_M |=>
		wr_en_out && wr_data_out == $past(src2_in)) else $error("copy");
	const_load_a: assert property (go && op_in == `HMME_OP_CONST && on_s |=>
		wr_en_out && wr_data_out == {{16{$past(cst16_in[15])}}, $past(cst16_in)}) else $error("const");
	upper_load_a: assert property (go && op_in == `HMME_OP_UPPER && on_s |=>
		wr_data_out == {$past(cst16_in), $past(dst_old_in[15:0])}) else $error("upper");
	false_cond_a: assert property (issue_in && !cond_in |=> !wr_en_out && !illegal_unit_out)
		else $error("false cond");
	ctl_unit_a: assert property (go && op_in == `HMME_OP_CTL_WR && unit_in != `HMME_UNIT_S2 |=>
		illegal_unit_out && $stable(amr_out)) else $error("ctl unit");
	amr_resv_a: assert property (amr_out[31:26] == 6'h00) else $error("amr reserved");
	amr_write_a: assert property (cw2 && ctl_addr_in == 5'h00 |=>
		amr_out == ($past(src2_in) & 32'h03ff_ffff)) else $error("amr write");
	iflag_set_a: assert property (cw2 && ctl_addr_in == 5'h02 |=> $stable(iflag_out) ##1
		(iflag_out & $past(src2_in, 2)) == $past(src2_in, 2)) else $error("iflag set");
endmodule

bind hmme_exec hmme_exec_props hmme_exec_props_inst (.ref_clk_in, .nrst_in, .issue_in, .cond_in, .op_in,
	.unit_in, .ctl_addr_in, .cst16_in, .src1_in, .src2_in, .dst_old_in, .wr_en_out, .illegal_unit_out,
	.wr_data_out, .amr_out, .iflag_out);

// File: dv/hmme_regfile_model.sv
// Register file beside the issue stage: takes writebacks, returns old destination.
// Assumes one writeback strobe per result.
`timescale 1ns/1ps
module hmme_regfile_model (
	input  wire        ref_clk_in,
	input  wire        wr_en_in,
	input  wire [4:0]  wr_addr_in,
	input  wire [31:0] wr_data_in,
	input  wire [4:0]  rd_addr_in,
	output wire [31:0] rd_data_out
);
	logic [31:0] regs_q [32];
	always @(posedge ref_clk_in) begin
		if (wr_en_in)
			regs_q[wr_addr_in] <= wr_data_in;
	end
	assign rd_data_out = regs_q[rd_addr_in];
endmodule

// File: dv/tb_hmme_exec.sv
// Self-checking bench for hmme_exec: multiplies, moves, control transfers.
// Assumes the register file model supplies the old destination value.
`timescale 1ns/1ps
`include "hmme_defs.vh"
module tb_hmme_exec;
	logic        ref_clk_in = 0, nrst_in = 0, issue_in = 0, cond_in = 0, src1_is_cst5_in = 0;
	logic [3:0]  op_in = 0;
	logic [2:0]  unit_in = 0;
	logic [4:0]  cst5_in = 0, dst_addr_in = 0, ctl_addr_in = 0, wr_addr_out;
	logic [15:0] cst16_in = 0;
	logic [31:0] src1_in = 0, src2_in = 0, dst_old_in, wr_data_out, amr_out, iflag_out;
	logic [31:0] pc_e1_in = 32'h0000_0400;
	logic        wr_en_out, illegal_unit_out;
	int          error_cnt = 0, checks = 0, cyc = 0;
	always #25 ref_clk_in = ~ref_clk_in;
	hmme_exec hmme_exec_inst (.ref_clk_in, .nrst_in, .issue_in, .op_in, .unit_in, .cond_in, .src1_in,
		.src1_is_cst5_in, .cst5_in, .src2_in, .cst16_in, .dst_old_in, .dst_addr_in, .ctl_addr_in, .pc_e1_in,
		.ctl_csr_in(32'h0), .wr_en_out, .wr_addr_out, .wr_data_out, .illegal_unit_out, .amr_out, .csr_out(),
		.iflag_out, .ien_out(), .vtp_out(), .irp_out(), .nrp_out());
	hmme_regfile_model hmme_regfile_model_inst (.ref_clk_in, .wr_en_in(wr_en_out), .wr_addr_in(wr_addr_out),
		.wr_data_in(wr_data_out), .rd_addr_in(dst_addr_in), .rd_data_out(dst_old_in));
	task automatic end_sim();
		if (error_cnt == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Unused operand fields double as addresses and immediate
	task automatic run(input logic [3:0] o, input logic [2:0] u, input logic c, input logic [31:0] x, y,
		input int lat);
		@(posedge ref_clk_in);
		op_in <= o;
		unit_in <= u;
		cond_in <= c;
		issue_in <= 1'h1;
		src1_in <= x;
		src2_in <= y;
		cst16_in <= y[15:0];
		dst_addr_in <= x[4:0];
		ctl_addr_in <= x[4:0];
		@(posedge ref_clk_in);
		issue_in <= 1'h0;
		repeat (lat) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic mul(input logic [3:0] o, input logic [31:0] x, y, exp);
		// Look right after the issue edge: the slot after issue must stay quiet
		run(o, `HMME_UNIT_M, 1'h1, x, y, 0);
		chk("mul slot", {31'h0, wr_en_out}, 32'h0);
		@(posedge ref_clk_in);
		#1;
		chk("product", wr_data_out, exp);
	endtask
	task automatic t_mul();
		logic [31:0] x, y;
		x = 32'h1234_fff3;
		y = 32'h8000_fffd;
		mul(`HMME_OP_MUL_ULUL, x, y, x[15:0] * y[15:0]);
		mul(`HMME_OP_MUL_ULSH, x, y, $signed({1'b0, x[15:0]}) * $signed(y[31:16]));
		mul(`HMME_OP_MUL_SLUL, x, y, $signed(x[15:0]) * $signed({1'b0, y[15:0]}));
		mul(`HMME_OP_MUL_ULSL, x, y, $signed({1'b0, x[15:0]}) * $signed(y[15:0]));
		@(posedge ref_clk_in);
		src1_is_cst5_in <= 1'h1;
		cst5_in <= 5'h13;
		mul(`HMME_OP_MUL_SLUL, x, y, 32'hfff3_0027);
		src1_is_cst5_in <= 1'h0;
	endtask
	task automatic t_move();
		logic [2:0] units [3] = '{`HMME_UNIT_L, `HMME_UNIT_S1, `HMME_UNIT_D};
		foreach (units[i]) begin
			// The single-cycle write strobe stands only in the cycle after the issue edge
			run(`HMME_OP_COPY, units[i], 1'h1, 32'h3, 32'h8765_4321 + i, 0);
			chk("copy", wr_data_out, 32'h8765_4321 + i);
			chk("copy strobe", {31'h0, wr_en_out}, 32'h1);
			chk("copy addr", {27'h0, wr_addr_out}, 32'h3);
		end
		run(`HMME_OP_COPY, `HMME_UNIT_L, 1'h0, 32'h3, 32'h1, 0);
		chk("false cond", {30'h0, wr_en_out, illegal_unit_out}, 32'h0);
		run(`HMME_OP_CONST, `HMME_UNIT_S2, 1'h1, 32'h3, 32'hc678, 0);
		chk("const", wr_data_out, 32'hffff_c678);
		chk("const strobe", {31'h0, wr_en_out}, 32'h1);
		run(`HMME_OP_UPPER, `HMME_UNIT_S1, 1'h1, 32'h3, 32'h07a8, 0);
		chk("upper", wr_data_out, 32'h07a8_c678);
	endtask
	task automatic t_ctl();
		run(`HMME_OP_CTL_WR, `HMME_UNIT_S2, 1'h1, 32'h0, 32'hf009_0001, 0);
		chk("amr", amr_out, 32'h0009_0001);
		// Illegal-unit flag is a one-cycle pulse
		run(`HMME_OP_CTL_WR, `HMME_UNIT_S1, 1'h1, 32'h0, 32'h1, 0);
		chk("bad unit", {illegal_unit_out, amr_out[30:0]}, 32'h8009_0001);
		// Flag view lags the set write by one extra cycle
		run(`HMME_OP_CTL_WR, `HMME_UNIT_S2, 1'h1, 32'h2, 32'h5, 0);
		chk("iflag early", iflag_out, 32'h0);
		run(`HMME_OP_CTL_RD, `HMME_UNIT_S2, 1'h1, 32'h2, 32'h0, 0);
		chk("iflag read", wr_data_out, 32'h5);
		run(`HMME_OP_CTL_WR, `HMME_UNIT_S2, 1'h1, 32'h3, 32'h1, 2);
		chk("iflag clear", iflag_out, 32'h4);
		run(`HMME_OP_CTL_RD, `HMME_UNIT_S2, 1'h1, 32'h3, 32'h0, 0);
		chk("clear read", wr_data_out, 32'h0);
		run(`HMME_OP_CTL_RD, `HMME_UNIT_S2, 1'h1, 32'h10, 32'h0, 0);
		chk("pc read", wr_data_out, pc_e1_in);
		run(`HMME_OP_CTL_RD, `HMME_UNIT_S2, 1'h1, 32'h0, 32'h0, 0);
		chk("amr read", wr_data_out, 32'h0009_0001);
	endtask
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			end_sim();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk_in);
		nrst_in <= 1'h1;
		t_mul();
		t_move();
		t_ctl();
		end_sim();
	end
endmodule
